// [rtl/blcd_decoder.sv]
// Rotor position decoder: sensor code to top and bottom phase commands.
`timescale 1ns/1ps
`default_nettype none
`include "blcd_defs.svh"
module blcd_decoder (
  // Decoder link
  blcd_drv_if.dec drv
);
  blcd_pkg::blcd_phase_t code120;
  blcd_pkg::blcd_phase_t fwd_top;
  blcd_pkg::blcd_phase_t fwd_bot;
  logic ok;

  always_comb begin
    code120 = drv.hall;
    if (drv.sel60) begin
      if (drv.hall == `BLCD_C60_ALL_HIGH) begin
        code120 = `BLCD_C120_FOR_HIGH;
      end else if (drv.hall == `BLCD_C60_ALL_LOW) begin
        code120 = `BLCD_C120_FOR_LOW;
      end else if (drv.hall == `BLCD_C120_FOR_HIGH || drv.hall == `BLCD_C120_FOR_LOW) begin
        code120 = `BLCD_C60_ALL_HIGH;
      end
    end
  end

  always_comb begin
    ok = 1'b1;
    fwd_top = `BLCD_PH_NONE;
    fwd_bot = `BLCD_PH_NONE;
    case (code120)
      3'h4: begin
        fwd_top = `BLCD_PH_A;
        fwd_bot = `BLCD_PH_C;
      end
      3'h6: begin
        fwd_top = `BLCD_PH_B;
        fwd_bot = `BLCD_PH_C;
      end
      3'h2: begin
        fwd_top = `BLCD_PH_B;
        fwd_bot = `BLCD_PH_A;
      end
      3'h3: begin
        fwd_top = `BLCD_PH_C;
        fwd_bot = `BLCD_PH_A;
      end
      3'h1: begin
        fwd_top = `BLCD_PH_C;
        fwd_bot = `BLCD_PH_B;
      end
      3'h5: begin
        fwd_top = `BLCD_PH_A;
        fwd_bot = `BLCD_PH_B;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
  end

  // Reverse direction swaps top and bottom of the same phase letter.
  assign drv.top = drv.fwd ? fwd_top : fwd_bot;
  assign drv.bot = drv.fwd ? fwd_bot : fwd_top;
  assign drv.valid = ok;
endmodule
`default_nettype wire

// [rtl/blcd_defs.svh]
// Register offsets, field positions and reset values of the commutation decoder.
`ifndef BLCD_DEFS_SVH
`define BLCD_DEFS_SVH
`define BLCD_ADDR_W 8
`define BLCD_CTRL_OFS 8'h00
`define BLCD_STATUS_OFS 8'h04
`define BLCD_IRQ_STAT_OFS 8'h08
`define BLCD_IRQ_MASK_OFS 8'h0C
`define BLCD_CTRL_RUN 0
`define BLCD_CTRL_BRAKE 1
`define BLCD_CTRL_RST 2'h1
`define BLCD_IRQ_W 4
`define BLCD_IRQ_INVALID 0
`define BLCD_IRQ_OVERCUR 1
`define BLCD_IRQ_FAULT 2
`define BLCD_IRQ_BRAKE 3
`define BLCD_IRQ_MASK_RST 4'h0
`define BLCD_RESP_OKAY 2'h0
`define BLCD_RESP_SLVERR 2'h2
`define BLCD_C60_ALL_HIGH 3'h7
`define BLCD_C60_ALL_LOW 3'h0
`define BLCD_C120_FOR_HIGH 3'h2
`define BLCD_C120_FOR_LOW 3'h5
`define BLCD_PH_A 3'h4
`define BLCD_PH_B 3'h2
`define BLCD_PH_C 3'h1
`define BLCD_PH_NONE 3'h0
`define BLCD_PH_ALL 3'h7
`endif

// [rtl/blcd_drv_if.sv]
// Link between the core and the rotor position decoder.
`timescale 1ns/1ps
`default_nettype none
interface blcd_drv_if;
  blcd_pkg::blcd_phase_t hall;
  logic sel60;
  logic fwd;
  blcd_pkg::blcd_phase_t top;
  blcd_pkg::blcd_phase_t bot;
  logic valid;
  modport core (output hall, output sel60, output fwd, input top, input bot, input valid);
  modport dec (input hall, input sel60, input fwd, output top, output bot, output valid);
endinterface
`default_nettype wire

// [rtl/blcd_irq.sv]
// Sticky interrupt status with write-one-to-clear, mask and one level output.
`timescale 1ns/1ps
`default_nettype none
`include "blcd_defs.svh"
module blcd_irq #(
  parameter int W = `BLCD_IRQ_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Events and software access
  input wire logic [W-1:0] evt,
  input wire logic clr_we,
  input wire logic [W-1:0] clr_data,
  input wire logic mask_we,
  input wire logic [W-1:0] mask_data,
  // State
  output logic [W-1:0] stat,
  output logic [W-1:0] mask,
  output logic irq
);
  logic [W-1:0] stat_r;
  logic [W-1:0] stat_nxt;
  logic [W-1:0] mask_r;
  logic [W-1:0] mask_nxt;
  logic irq_r;
  logic irq_nxt;

  // A new event wins over a clear in the same cycle.
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign stat_nxt[i] = evt[i] | (stat_r[i] & ~(clr_we & clr_data[i]));
  end

  always_comb begin
    mask_nxt = mask_we ? mask_data : mask_r;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_r <= '0;
      mask_r <= `BLCD_IRQ_MASK_RST;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign stat = stat_r;
  assign mask = mask_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// [rtl/blcd_pkg.sv]
// Types shared by the commutation decoder modules.
package blcd_pkg;
  typedef logic [2:0] blcd_phase_t;
  typedef enum logic [1:0] {
    BLCD_RUN = 2'b00,
    BLCD_COAST = 2'b01,
    BLCD_BRAKE = 2'b10,
    BLCD_LIMIT = 2'b11
  } blcd_mode_t;
endpackage

// [rtl/blcd_top.sv]
// Commutation and protection logic of a three-phase brushless motor controller.
//
// Operation
// - Fault goes low on an invalid sensor code, enable low, overcurrent, undervoltage or overheat.
// - Phasing select high decodes the 60 degree convention, low the 120 degree one.
// - The motor may run only while brake is low; brake high stops running and brakes.
// - Six of the eight sensor codes are valid 60 degree positions and two are invalid.
// - A change of direction with the same code swaps each active top and bottom of one phase.
// - Enable low turns all tops off, all bottoms off so the motor coasts, and pulls fault low.
// - Brake high turns all tops off and all bottoms on, shorting the windings.
// - Brake takes priority over sensor, direction and enable inputs for the drives.
// - Braking bottoms wait until all three top commands are off, by a four-input interlock.
// - The interlock looks at the internal top commands, not at the top pins.
// - Top drives and fault are active low.
// - An invalid code without brake turns all drives off and pulls fault low.
// - An invalid code with brake turns tops off, bottoms on, and pulls fault low.
// - Overcurrent ends bottom switch conduction for the rest of the oscillator cycle; the active top stays on.
`timescale 1ns/1ps
`default_nettype none
`include "blcd_defs.svh"
module blcd_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Sensors and control inputs
  input wire logic hall_input_a,
  input wire logic hall_input_b,
  input wire logic hall_input_c,
  input wire logic phase_sel_60,
  input wire logic dir_fwd,
  input wire logic out_enable,
  input wire logic brake,
  input wire logic over_current,
  input wire logic uv_lockout,
  input wire logic thermal_trip,
  input wire logic osc_cycle_start,
  // Power switch drives and fault
  output logic upper_switch_a_b,
  output logic upper_switch_b_b,
  output logic upper_switch_c_b,
  output logic lower_switch_a,
  output logic lower_switch_b,
  output logic lower_switch_c,
  output logic fault_b,
  output logic irq,
  // AXI4-Lite write
  input wire logic [`BLCD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [`BLCD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ------------------------------------------------------------
  // Decoder and drive state
  // ------------------------------------------------------------
  blcd_drv_if drv ();
  blcd_decoder u_dec (
    .drv(drv)
  );

  blcd_pkg::blcd_phase_t hall_code;
  blcd_pkg::blcd_phase_t upper_n_r;
  blcd_pkg::blcd_phase_t upper_n_nxt;
  blcd_pkg::blcd_phase_t lower_r;
  blcd_pkg::blcd_phase_t lower_nxt;
  blcd_pkg::blcd_mode_t mode_r;
  blcd_pkg::blcd_mode_t mode_nxt;
  logic fault_b_r;
  logic fault_b_nxt;
  logic oc_latch_r;
  logic oc_latch_nxt;
  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;
  logic brake_eff;
  logic enable_eff;
  logic tops_idle;
  logic limit;
  logic [`BLCD_IRQ_W-1:0] irq_evt;
  logic [`BLCD_IRQ_W-1:0] irq_stat;
  logic [`BLCD_IRQ_W-1:0] irq_mask;
  logic irq_w;

  assign hall_code = {hall_input_a, hall_input_b, hall_input_c};
  assign drv.hall = hall_code;
  assign drv.sel60 = phase_sel_60;
  assign drv.fwd = dir_fwd;
  assign brake_eff = brake | ctrl_r[`BLCD_CTRL_BRAKE];
  assign enable_eff = out_enable & ctrl_r[`BLCD_CTRL_RUN];
  // Four-input interlock on the brake and the internal top commands.
  assign tops_idle = brake_eff & (upper_n_r == `BLCD_PH_ALL);
  assign limit = over_current | oc_latch_r;

  always_comb begin
    oc_latch_nxt = over_current | (oc_latch_r & ~osc_cycle_start);
    fault_b_nxt = ~(~drv.valid | ~enable_eff | over_current | uv_lockout | thermal_trip);
    if (brake_eff) begin
      mode_nxt = blcd_pkg::BLCD_BRAKE;
    end else if (!enable_eff || !drv.valid || uv_lockout || thermal_trip) begin
      mode_nxt = blcd_pkg::BLCD_COAST;
    end else if (limit) begin
      mode_nxt = blcd_pkg::BLCD_LIMIT;
    end else begin
      mode_nxt = blcd_pkg::BLCD_RUN;
    end
    unique case (mode_nxt)
      blcd_pkg::BLCD_BRAKE: begin
        upper_n_nxt = `BLCD_PH_ALL;
        lower_nxt = tops_idle ? `BLCD_PH_ALL : `BLCD_PH_NONE;
      end
      blcd_pkg::BLCD_COAST: begin
        upper_n_nxt = `BLCD_PH_ALL;
        lower_nxt = `BLCD_PH_NONE;
      end
      blcd_pkg::BLCD_LIMIT: begin
        upper_n_nxt = ~drv.top;
        lower_nxt = `BLCD_PH_NONE;
      end
      blcd_pkg::BLCD_RUN: begin
        upper_n_nxt = ~drv.top;
        lower_nxt = drv.bot & ~drv.top;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      upper_n_r <= `BLCD_PH_ALL;
      lower_r <= `BLCD_PH_NONE;
      mode_r <= blcd_pkg::BLCD_COAST;
      fault_b_r <= 1'b0;
      oc_latch_r <= 1'b0;
    end else begin
      upper_n_r <= upper_n_nxt;
      lower_r <= lower_nxt;
      mode_r <= mode_nxt;
      fault_b_r <= fault_b_nxt;
      oc_latch_r <= oc_latch_nxt;
    end
  end

  assign upper_switch_a_b = upper_n_r[2];
  assign upper_switch_b_b = upper_n_r[1];
  assign upper_switch_c_b = upper_n_r[0];
  assign lower_switch_a = lower_r[2];
  assign lower_switch_b = lower_r[1];
  assign lower_switch_c = lower_r[0];
  assign fault_b = fault_b_r;

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  logic [1:0] aw_w_hold_r;
  logic [`BLCD_ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic w_lane0_r;
  logic wr_do;

  always_comb begin
    irq_evt = '0;
    irq_evt[`BLCD_IRQ_INVALID] = ~drv.valid;
    irq_evt[`BLCD_IRQ_OVERCUR] = over_current;
    irq_evt[`BLCD_IRQ_FAULT] = fault_b_r & ~fault_b_nxt;
    irq_evt[`BLCD_IRQ_BRAKE] = brake_eff & (mode_r != blcd_pkg::BLCD_BRAKE);
  end

  blcd_irq #(
    .W(`BLCD_IRQ_W)
  ) u_irq (
    .clk(clk),
    .rst_b(rst_b),
    .evt(irq_evt),
    .clr_we(wr_do && aw_addr_r == `BLCD_IRQ_STAT_OFS && w_lane0_r),
    .clr_data(w_data_r[`BLCD_IRQ_W-1:0]),
    .mask_we(wr_do && aw_addr_r == `BLCD_IRQ_MASK_OFS && w_lane0_r),
    .mask_data(w_data_r[`BLCD_IRQ_W-1:0]),
    .stat(irq_stat),
    .mask(irq_mask),
    .irq(irq_w)
  );
  assign irq = irq_w;

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  logic [1:0] aw_w_hold_nxt;
  logic [`BLCD_ADDR_W-1:0] aw_addr_nxt;
  logic [31:0] w_data_nxt;
  logic w_lane0_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic aw_take, w_take, ar_take, wr_map, rd_map;
  logic [31:0] rd_word;

  assign aw_take = s_axi_awvalid & awready_r;
  assign w_take = s_axi_wvalid & wready_r;
  assign ar_take = s_axi_arvalid & arready_r;
  assign wr_do = aw_w_hold_r[0] & aw_w_hold_r[1] & ~bvalid_r;
  assign wr_map = aw_addr_r == `BLCD_CTRL_OFS || aw_addr_r == `BLCD_STATUS_OFS ||
                  aw_addr_r == `BLCD_IRQ_STAT_OFS || aw_addr_r == `BLCD_IRQ_MASK_OFS;

  always_comb begin
    rd_map = 1'b1;
    unique case (s_axi_araddr)
      `BLCD_CTRL_OFS: rd_word = {30'h0, ctrl_r};
      `BLCD_STATUS_OFS: rd_word = {18'h0, lower_r, ~upper_n_r, oc_latch_r, mode_r,
                                  ~fault_b_r, drv.valid, hall_code};
      `BLCD_IRQ_STAT_OFS: rd_word = {28'h0, irq_stat};
      `BLCD_IRQ_MASK_OFS: rd_word = {28'h0, irq_mask};
      default: begin
        rd_word = 32'h0;
        rd_map = 1'b0;
      end
    endcase
  end

  always_comb begin
    aw_w_hold_nxt = aw_w_hold_r;
    if (wr_do) begin
      aw_w_hold_nxt = 2'h0;
    end else begin
      aw_w_hold_nxt[0] = aw_w_hold_r[0] | aw_take;
      aw_w_hold_nxt[1] = aw_w_hold_r[1] | w_take;
    end
    aw_addr_nxt = aw_take ? s_axi_awaddr : aw_addr_r;
    w_data_nxt = w_take ? s_axi_wdata : w_data_r;
    w_lane0_nxt = w_take ? s_axi_wstrb[0] : w_lane0_r;
    bvalid_nxt = wr_do | (bvalid_r & ~s_axi_bready);
    bresp_nxt = wr_do ? (wr_map ? `BLCD_RESP_OKAY : `BLCD_RESP_SLVERR) : bresp_r;
    awready_nxt = ~aw_w_hold_nxt[0] & ~bvalid_nxt & ~wr_do;
    wready_nxt = ~aw_w_hold_nxt[1] & ~bvalid_nxt & ~wr_do;
    ctrl_nxt = ctrl_r;
    if (wr_do && aw_addr_r == `BLCD_CTRL_OFS && w_lane0_r) begin
      ctrl_nxt = w_data_r[1:0];
    end
    rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);
    arready_nxt = ~rvalid_nxt;
    rdata_nxt = ar_take ? rd_word : rdata_r;
    rresp_nxt = ar_take ? (rd_map ? `BLCD_RESP_OKAY : `BLCD_RESP_SLVERR) : rresp_r;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_w_hold_r <= 2'h0;
      aw_addr_r <= '0;
      w_data_r <= 32'h0;
      w_lane0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `BLCD_RESP_OKAY;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      ctrl_r <= `BLCD_CTRL_RST;
      rvalid_r <= 1'b0;
      arready_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `BLCD_RESP_OKAY;
    end else begin
      aw_w_hold_r <= aw_w_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_lane0_r <= w_lane0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      ctrl_r <= ctrl_nxt;
      rvalid_r <= rvalid_nxt;
      arready_r <= arready_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking sample_edge @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic run_ok;
  assign run_ok = ~brake_eff & enable_eff & drv.valid & ~uv_lockout & ~thermal_trip & ~limit;

  sequence s_brake_two;
    brake_eff [*2];
  endsequence
  sequence s_reverse;
    run_ok ##1 (run_ok && $changed(dir_fwd) && $stable(hall_code));
  endsequence

  a_fault_cause: assert property ((!drv.valid || !enable_eff || over_current || uv_lockout ||
    thermal_trip) |=> !fault_b_r) else $error("fault not shown for a cause");
  a_fault_clear: assert property ((drv.valid && enable_eff && !over_current && !uv_lockout &&
    !thermal_trip) |=> fault_b_r) else $error("fault shown without cause");
  a_brake_tops_off: assert property (brake_eff |=> upper_n_r == `BLCD_PH_ALL)
    else $error("top on during brake");
  a_brake_bottoms_on: assert property (s_brake_two |=> lower_r == `BLCD_PH_ALL)
    else $error("bottoms not on after brake");
  a_brake_interlock: assert property ((brake_eff && upper_n_r != `BLCD_PH_ALL) |=>
    lower_r == `BLCD_PH_NONE) else $error("bottoms on before tops off");
  a_coast_off: assert property ((!brake_eff && (!enable_eff || !drv.valid)) |=>
    (upper_n_r == `BLCD_PH_ALL && lower_r == `BLCD_PH_NONE)) else $error("drive during coast");
  a_invalid_brake: assert property ((brake_eff && !drv.valid) [*2] |=>
    (lower_r == `BLCD_PH_ALL && !fault_b_r)) else $error("invalid brake wrong");
  a_run_one_each: assert property ((mode_r == blcd_pkg::BLCD_RUN) |->
    ($onehot(~upper_n_r) && $onehot(lower_r))) else $error("run drive not one each");
  a_no_shoot: assert property ((~upper_n_r & lower_r) == `BLCD_PH_NONE)
    else $error("same phase top and bottom on");
  a_dir_swap: assert property (s_reverse |=> (~upper_n_r == $past(lower_r)))
    else $error("direction change did not swap");
  a_oc_limit: assert property ((over_current ##1 (!osc_cycle_start && !brake_eff)) |=>
    lower_r == `BLCD_PH_NONE)
    else $error("conduction during current limit");
endmodule
`default_nettype wire

// [test/blcd_hall_model.sv]
// Hall sensor set and power bridge model at the far side of the decoder.
`timescale 1ns/1ps
`default_nettype none
`include "blcd_defs.svh"
module blcd_hall_model (
  // Rotor position and sensor faults
  input wire logic [2:0] step,
  input wire logic sel60,
  input wire logic [1:0] bad,
  // Sensor lines
  output logic hall_a,
  output logic hall_b,
  output logic hall_c,
  // Bridge gates, active high
  input wire logic [2:0] tops_on,
  input wire logic [2:0] bots_on,
  output logic shoot
);
  // Sensor codes of the six rotor positions in each phasing.
  localparam logic [2:0] c120 [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
  localparam logic [2:0] c60 [6] = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};
  logic [2:0] code;
  // Open sensors read all high and shorted ones all low in 120 degree phasing; in 60 degree phasing they read 5 and 2.
  always_comb begin
    if (bad == 2'h1) begin
      code = sel60 ? 3'h5 : 3'h7;
    end else if (bad == 2'h2) begin
      code = sel60 ? 3'h2 : 3'h0;
    end else begin
      code = sel60 ? c60[step] : c120[step];
    end
  end
  assign {hall_a, hall_b, hall_c} = code;
  // A leg whose two switches conduct together shorts the supply.
  assign shoot = |(tops_on & bots_on);
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking testbench of the commutation decoder.
`timescale 1ns/1ps
`default_nettype none
`include "blcd_defs.svh"
module testbench;
  localparam logic [2:0] top_tab [6] = '{`BLCD_PH_A, `BLCD_PH_B, `BLCD_PH_B, `BLCD_PH_C,
    `BLCD_PH_C, `BLCD_PH_A};
  localparam logic [2:0] bot_tab [6] = '{`BLCD_PH_C, `BLCD_PH_C, `BLCD_PH_A, `BLCD_PH_A,
    `BLCD_PH_B, `BLCD_PH_B};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] step = 3'h0;
  logic [1:0] bad = 2'h0;
  logic hall_input_a, hall_input_b, hall_input_c, shoot;
  logic phase_sel_60 = 1'b0, dir_fwd = 1'b1, out_enable = 1'b1, brake = 1'b0;
  logic over_current = 1'b0, uv_lockout = 1'b0, thermal_trip = 1'b0, osc_cycle_start = 1'b0;
  logic upper_switch_a_b, upper_switch_b_b, upper_switch_c_b;
  logic lower_switch_a, lower_switch_b, lower_switch_c, fault_b, irq;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0] tops_on, bots_on;
  int n_errors = 0;
  int n_tests = 0;
  assign tops_on = ~{upper_switch_a_b, upper_switch_b_b, upper_switch_c_b};
  assign bots_on = {lower_switch_a, lower_switch_b, lower_switch_c};
  always #50 clk = ~clk;
  blcd_top DUT (.clk, .rst_b, .hall_input_a, .hall_input_b, .hall_input_c, .phase_sel_60,
    .dir_fwd, .out_enable, .brake, .over_current, .uv_lockout, .thermal_trip,
    .osc_cycle_start, .upper_switch_a_b, .upper_switch_b_b, .upper_switch_c_b,
    .lower_switch_a, .lower_switch_b, .lower_switch_c, .fault_b, .irq, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  blcd_hall_model motor (.step(step), .sel60(phase_sel_60), .bad(bad), .hall_a(hall_input_a),
    .hall_b(hall_input_b), .hall_c(hall_input_c), .tops_on(tops_on), .bots_on(bots_on),
    .shoot(shoot));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic expect_drv(input string name, input logic [2:0] top, input logic [2:0] bot,
    input logic flt);
    check(name, {25'h0, tops_on, bots_on, fault_b}, {25'h0, top, bot, flt});
    check("shoot-through", {31'h0, shoot}, 32'h0);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("write response", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input string name, input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(name, s_axi_rdata, ed);
    check("read response", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    #1;
    expect_drv("reset drives", 3'h0, 3'h0, 1'b0);
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    axi_rd("ctrl reset", `BLCD_CTRL_OFS, 32'h1, `BLCD_RESP_OKAY);
    axi_rd("mask reset", `BLCD_IRQ_MASK_OFS, 32'h0, `BLCD_RESP_OKAY);
    axi_rd("unmapped read", 8'h10, 32'h0, `BLCD_RESP_SLVERR);
    axi_wr(8'h10, 32'hF, `BLCD_RESP_SLVERR);
    $display("test registers done");
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 6; k++) begin
        for (int d = 1; d >= 0; d--) begin
          @(posedge clk);
          phase_sel_60 <= s[0];
          step <= k[2:0];
          dir_fwd <= d[0];
          settle();
          if (d == 1) begin
            expect_drv("run forward", top_tab[k], bot_tab[k], 1'b1);
          end else begin
            expect_drv("run reverse", bot_tab[k], top_tab[k], 1'b1);
          end
        end
      end
    end
    $display("test commutation done");
    for (int s = 0; s < 2; s++) begin
      for (int b = 1; b < 3; b++) begin
        for (int r = 0; r < 2; r++) begin
          @(posedge clk);
          phase_sel_60 <= s[0];
          bad <= b[1:0];
          brake <= r[0];
          settle();
          expect_drv("invalid code", 3'h0, r ? 3'h7 : 3'h0, 1'b0);
        end
      end
    end
    @(posedge clk);
    bad <= 2'h0;
    brake <= 1'b0;
    phase_sel_60 <= 1'b0;
    step <= 3'h0;
    dir_fwd <= 1'b1;
    settle();
    @(posedge clk);
    brake <= 1'b1;
    @(posedge clk);
    #1;
    check("tops off first", {29'h0, tops_on}, 32'h0);
    check("bottoms held", {31'h0, bots_on == 3'h7}, 32'h0);
    @(posedge clk);
    #1;
    expect_drv("brake", 3'h0, 3'h7, 1'b1);
    @(posedge clk);
    out_enable <= 1'b0;
    step <= 3'h3;
    dir_fwd <= 1'b0;
    settle();
    expect_drv("brake priority", 3'h0, 3'h7, 1'b0);
    @(posedge clk);
    brake <= 1'b0;
    settle();
    expect_drv("coast", 3'h0, 3'h0, 1'b0);
    @(posedge clk);
    out_enable <= 1'b1;
    step <= 3'h0;
    dir_fwd <= 1'b1;
    settle();
    expect_drv("run again", `BLCD_PH_A, `BLCD_PH_C, 1'b1);
    $display("test brake and enable done");
    @(posedge clk);
    over_current <= 1'b1;
    settle();
    expect_drv("current limit", `BLCD_PH_A, 3'h0, 1'b0);
    @(posedge clk);
    over_current <= 1'b0;
    settle();
    expect_drv("limit latched", `BLCD_PH_A, 3'h0, 1'b1);
    @(posedge clk);
    osc_cycle_start <= 1'b1;
    @(posedge clk);
    osc_cycle_start <= 1'b0;
    settle();
    expect_drv("limit cleared", `BLCD_PH_A, `BLCD_PH_C, 1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      uv_lockout <= (i == 0);
      thermal_trip <= (i == 1);
      settle();
      expect_drv("protection", i < 2 ? 3'h0 : `BLCD_PH_A, i < 2 ? 3'h0 : `BLCD_PH_C,
        i == 2);
    end
    $display("test protection done");
    axi_wr(`BLCD_IRQ_STAT_OFS, 32'hF, `BLCD_RESP_OKAY);
    axi_rd("status cleared", `BLCD_IRQ_STAT_OFS, 32'h0, `BLCD_RESP_OKAY);
    @(posedge clk);
    bad <= 2'h1;
    settle();
    @(posedge clk);
    bad <= 2'h0;
    settle();
    axi_rd("status events", `BLCD_IRQ_STAT_OFS, 32'h5, `BLCD_RESP_OKAY);
    check("irq masked", {31'h0, irq}, 32'h0);
    axi_wr(`BLCD_IRQ_MASK_OFS, 32'h1, `BLCD_RESP_OKAY);
    settle();
    check("irq raised", {31'h0, irq}, 32'h1);
    axi_wr(`BLCD_IRQ_STAT_OFS, 32'h1, `BLCD_RESP_OKAY);
    settle();
    check("irq cleared", {31'h0, irq}, 32'h0);
    axi_rd("status left", `BLCD_IRQ_STAT_OFS, 32'h4, `BLCD_RESP_OKAY);
    $display("test interrupts done");
    axi_wr(`BLCD_CTRL_OFS, 32'h3, `BLCD_RESP_OKAY);
    settle();
    expect_drv("soft brake", 3'h0, 3'h7, 1'b1);
    axi_wr(`BLCD_CTRL_OFS, 32'h0, `BLCD_RESP_OKAY);
    settle();
    expect_drv("soft stop", 3'h0, 3'h0, 1'b0);
    axi_wr(`BLCD_CTRL_OFS, 32'h1, `BLCD_RESP_OKAY);
    settle();
    expect_drv("soft run", `BLCD_PH_A, `BLCD_PH_C, 1'b1);
    axi_wr(`BLCD_STATUS_OFS, 32'hFFFFFFFF, `BLCD_RESP_OKAY);
    axi_rd("status word", `BLCD_STATUS_OFS, 32'h00000C0C, `BLCD_RESP_OKAY);
    axi_rd("control events", `BLCD_IRQ_STAT_OFS, 32'hC, `BLCD_RESP_OKAY);
    $display("test control done");
    summarize();
  end
  // The tests take about three hundred cycles; a hang is cut well beyond that.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
